//--- common/tar_pkg.sv
// Package for the test access port and device reset block.
// Assumes one core clock domain; the block synchronises its raw pin inputs itself.
package tar_pkg;

    // Boundary-scan controller states
    typedef enum logic [3:0] {
        TAR_TLR, TAR_RTI, TAR_SEL_DR, TAR_CAP_DR, TAR_SH_DR, TAR_EX1_DR, TAR_PA_DR, TAR_EX2_DR, TAR_UPD_DR,
        TAR_SEL_IR, TAR_CAP_IR, TAR_SH_IR, TAR_EX1_IR, TAR_PA_IR, TAR_EX2_IR, TAR_UPD_IR
    } tar_state_t;

    localparam int           IR_W       = 4;
    localparam logic [3:0]   IR_IDCODE  = 4'h1;
    localparam logic [3:0]   IR_BYPASS  = 4'hf;
    localparam logic [3:0]   IR_CAPTURE = 4'h1;
    localparam logic [31:0]  IDCODE_DEF = 32'h0000_0001; // Arbitrary value, LSB must be 1
    localparam int           INIT_CYCLES = 16;

    // Sampled pin group
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
        logic trst_n;
        logic device_reset_n;
    } tar_pins_t;

endpackage : tar_pkg

//--- src/tar_top.sv
// Boundary-scan test port and device reset sequencer for one die.
// Assumes the test clock is far slower than i_core_clk (edges found by sampling).
`timescale 1ns/1ns
`default_nettype none
module tar_top #(
    parameter logic [31:0] IDCODE     = tar_pkg::IDCODE_DEF,
    parameter int          INIT_COUNT = tar_pkg::INIT_CYCLES
) (
    input  wire logic  i_core_clk,
    input  wire logic  i_reset,
    input  wire logic  i_clk_en,
    input  wire logic  i_tck,
    input  wire logic  i_tms,
    input  wire logic  i_tdi,
    input  wire logic  i_trst_n,
    input  wire logic  i_device_reset_n,
    output logic       o_tdo,
    output logic       o_tdo_oe,
    output logic       o_func_reset,
    output logic       o_standby,
    output logic       o_init_busy,
    output logic       o_load_defaults
);
    // Init counter is 16 bits; a longer init needs a wider count
    if (INIT_COUNT < 1 || INIT_COUNT > 65535) begin : g_bad_init
        $error("INIT_COUNT out of range");
    end
    if (IDCODE[0] != 1'b1) begin : g_bad_id
        $error("IDCODE bit 0 must be 1");
    end

    // Two-stage synchronisers; first stage read only by the second
    tar_pkg::tar_pins_t s1_r, s2_r, pin_raw;
    // Only the clock needs a third stage, for edge finding
    logic               tck_d_r;
    assign pin_raw = '{tck: i_tck, tms: i_tms, tdi: i_tdi, trst_n: i_trst_n, device_reset_n: i_device_reset_n};

    tar_pkg::tar_state_t st_r, st_nxt;
    logic [tar_pkg::IR_W-1:0] ir_r, ir_nxt, irsh_r, irsh_nxt;
    logic [31:0] dr_r, dr_nxt;
    logic        tdo_r, tdo_nxt, oe_r, oe_nxt;
    logic        rise, fall, trst;

    assign rise = s2_r.tck & ~tck_d_r;
    assign fall = ~s2_r.tck & tck_d_r;
    // Test reset acts as soon as seen, no test clock edge needed
    assign trst = ~s2_r.trst_n;

    always_comb begin
        st_nxt   = st_r;
        ir_nxt   = ir_r;
        irsh_nxt = irsh_r;
        dr_nxt   = dr_r;
        tdo_nxt  = tdo_r;
        oe_nxt   = oe_r;
        if (trst) begin
            st_nxt = tar_pkg::TAR_TLR;
            ir_nxt = tar_pkg::IR_IDCODE;
            oe_nxt = 1'b0;
        end else if (rise) begin
            // Inputs taken on the rising edge
            case (st_r)
                tar_pkg::TAR_TLR:    st_nxt = s2_r.tms ? tar_pkg::TAR_TLR    : tar_pkg::TAR_RTI;
                tar_pkg::TAR_RTI:    st_nxt = s2_r.tms ? tar_pkg::TAR_SEL_DR : tar_pkg::TAR_RTI;
                tar_pkg::TAR_SEL_DR: st_nxt = s2_r.tms ? tar_pkg::TAR_SEL_IR : tar_pkg::TAR_CAP_DR;
                tar_pkg::TAR_CAP_DR: st_nxt = s2_r.tms ? tar_pkg::TAR_EX1_DR : tar_pkg::TAR_SH_DR;
                tar_pkg::TAR_SH_DR:  st_nxt = s2_r.tms ? tar_pkg::TAR_EX1_DR : tar_pkg::TAR_SH_DR;
                tar_pkg::TAR_EX1_DR: st_nxt = s2_r.tms ? tar_pkg::TAR_UPD_DR : tar_pkg::TAR_PA_DR;
                tar_pkg::TAR_PA_DR:  st_nxt = s2_r.tms ? tar_pkg::TAR_EX2_DR : tar_pkg::TAR_PA_DR;
                tar_pkg::TAR_EX2_DR: st_nxt = s2_r.tms ? tar_pkg::TAR_UPD_DR : tar_pkg::TAR_SH_DR;
                tar_pkg::TAR_UPD_DR: st_nxt = s2_r.tms ? tar_pkg::TAR_SEL_DR : tar_pkg::TAR_RTI;
                tar_pkg::TAR_SEL_IR: st_nxt = s2_r.tms ? tar_pkg::TAR_TLR    : tar_pkg::TAR_CAP_IR;
                tar_pkg::TAR_CAP_IR: st_nxt = s2_r.tms ? tar_pkg::TAR_EX1_IR : tar_pkg::TAR_SH_IR;
                tar_pkg::TAR_SH_IR:  st_nxt = s2_r.tms ? tar_pkg::TAR_EX1_IR : tar_pkg::TAR_SH_IR;
                tar_pkg::TAR_EX1_IR: st_nxt = s2_r.tms ? tar_pkg::TAR_UPD_IR : tar_pkg::TAR_PA_IR;
                tar_pkg::TAR_PA_IR:  st_nxt = s2_r.tms ? tar_pkg::TAR_EX2_IR : tar_pkg::TAR_PA_IR;
                tar_pkg::TAR_EX2_IR: st_nxt = s2_r.tms ? tar_pkg::TAR_UPD_IR : tar_pkg::TAR_SH_IR;
                tar_pkg::TAR_UPD_IR: st_nxt = s2_r.tms ? tar_pkg::TAR_SEL_DR : tar_pkg::TAR_RTI;
                default:             st_nxt = tar_pkg::TAR_TLR;
            endcase
            case (st_r)
                tar_pkg::TAR_TLR:    ir_nxt = tar_pkg::IR_IDCODE;
                tar_pkg::TAR_CAP_IR: irsh_nxt = tar_pkg::IR_CAPTURE;
                tar_pkg::TAR_SH_IR:  irsh_nxt = {s2_r.tdi, irsh_r[tar_pkg::IR_W-1:1]};
                tar_pkg::TAR_UPD_IR: ir_nxt = irsh_r;
                // Same code on all dies since it is a fixed parameter
                tar_pkg::TAR_CAP_DR: dr_nxt = (ir_r == tar_pkg::IR_IDCODE) ? IDCODE : 32'h0000_0000;
                tar_pkg::TAR_SH_DR: begin
                    if (ir_r == tar_pkg::IR_IDCODE)
                        dr_nxt = {s2_r.tdi, dr_r[31:1]};
                    else
                        dr_nxt = {31'h0000_0000, s2_r.tdi}; // Bypass one-bit path
                end
                default: ;
            endcase
        end else if (fall) begin
            // Data output moves only on falling edge, enable also cleared by test reset; idle otherwise
            oe_nxt  = (st_r == tar_pkg::TAR_SH_DR) || (st_r == tar_pkg::TAR_SH_IR);
            tdo_nxt = (st_r == tar_pkg::TAR_SH_IR) ? irsh_r[0] : dr_r[0];
        end
    end

    // Device reset and initialization
    typedef enum logic [1:0] {TAR_RST, TAR_INIT, TAR_RUN} tar_dev_t;
    tar_dev_t   dv_r, dv_nxt;
    logic [15:0] cnt_r, cnt_nxt;
    logic        frst_r, frst_nxt, sby_r, sby_nxt, busy_r, busy_nxt, ld_r, ld_nxt;

    always_comb begin
        dv_nxt   = dv_r;
        cnt_nxt  = cnt_r;
        if (!s2_r.device_reset_n) begin
            dv_nxt = TAR_RST;
        end else begin
            case (dv_r)
                TAR_RST: begin
                    dv_nxt  = TAR_INIT;
                    // Counts down to zero, so init stands INIT_COUNT+1 cycles
                    cnt_nxt = 16'(INIT_COUNT);
                end
                TAR_INIT: begin
                    if (cnt_r == 16'h0000) dv_nxt = TAR_RUN;
                    else cnt_nxt = cnt_r - 16'h0001;
                end
                TAR_RUN: ;
                default: dv_nxt = TAR_RST;
            endcase
        end
        frst_nxt = (dv_nxt != TAR_RUN);
        sby_nxt  = (dv_nxt == TAR_RST);
        busy_nxt = (dv_nxt == TAR_INIT);
        // Defaults load exactly while busy, never after functions are released
        ld_nxt   = (dv_nxt == TAR_INIT);
    end

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            s1_r   <= '0;
            s2_r   <= '0;
            tck_d_r <= 1'b0;
            st_r   <= tar_pkg::TAR_TLR;
            ir_r   <= tar_pkg::IR_IDCODE;
            irsh_r <= '0;
            dr_r   <= '0;
            tdo_r  <= 1'b0;
            oe_r   <= 1'b0;
            dv_r   <= TAR_RST;
            cnt_r  <= '0;
            frst_r <= 1'b1;
            sby_r  <= 1'b1;
            busy_r <= 1'b0;
            ld_r   <= 1'b0;
        end else if (i_clk_en) begin
            s1_r   <= pin_raw;
            s2_r   <= s1_r;
            tck_d_r <= s2_r.tck;
            st_r   <= st_nxt;
            ir_r   <= ir_nxt;
            irsh_r <= irsh_nxt;
            dr_r   <= dr_nxt;
            tdo_r  <= tdo_nxt;
            oe_r   <= oe_nxt;
            dv_r   <= dv_nxt;
            cnt_r  <= cnt_nxt;
            frst_r <= frst_nxt;
            sby_r  <= sby_nxt;
            busy_r <= busy_nxt;
            ld_r   <= ld_nxt;
        end
    end

    assign o_tdo           = tdo_r;
    assign o_tdo_oe        = oe_r;
    assign o_func_reset    = frst_r;
    assign o_standby       = sby_r;
    assign o_init_busy     = busy_r;
    assign o_load_defaults = ld_r;

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_reset || !i_clk_en);

    sequence s_rel; $rose(s2_r.device_reset_n); endsequence
    sequence s_dr_shift; rise && !trst && st_r == tar_pkg::TAR_SH_DR; endsequence
    a_trst_forces_tlr: assert property (trst |=> st_r == tar_pkg::TAR_TLR) else $error("trst no TLR");
    a_trst_ir_reset: assert property (trst |=> ir_r == tar_pkg::IR_IDCODE && !o_tdo_oe)
        else $error("trst left ir or oe");
    a_tms_hold_tlr: assert property (rise && st_r == tar_pkg::TAR_TLR && s2_r.tms && !trst
        |=> st_r == tar_pkg::TAR_TLR) else $error("TLR not held");
    a_no_edge_hold: assert property (!rise && !trst |=> $stable(st_r)) else $error("state moved without edge");
    a_tdo_falls_only: assert property (!$past(fall) |-> $stable(o_tdo)) else $error("tdo off edge");
    a_rise_no_tdo: assert property (rise && !trst |=> $stable(o_tdo) && $stable(o_tdo_oe))
        else $error("tdo moved on rise");
    a_oe_when_shift: assert property (fall && !trst |=> o_tdo_oe == (st_r == tar_pkg::TAR_SH_DR
        || st_r == tar_pkg::TAR_SH_IR)) else $error("oe wrong");
    a_ir_shift_in: assert property (rise && !trst && st_r == tar_pkg::TAR_SH_IR
        |=> irsh_r[tar_pkg::IR_W-1] == $past(s2_r.tdi)) else $error("ir shift");
    a_ir_update: assert property (rise && !trst && st_r == tar_pkg::TAR_UPD_IR
        |=> ir_r == $past(irsh_r)) else $error("ir update");
    a_bypass_one_bit: assert property (s_dr_shift ##0 ir_r != tar_pkg::IR_IDCODE
        |=> dr_r == {31'h0000_0000, $past(s2_r.tdi)}) else $error("bypass path");
    a_idcode_cap: assert property (rise && !trst && st_r == tar_pkg::TAR_CAP_DR && ir_r == tar_pkg::IR_IDCODE
        |=> dr_r == IDCODE) else $error("idcode");
    a_sample_rise: assert property (s_dr_shift ##0 ir_r == tar_pkg::IR_IDCODE
        |=> dr_r[31] == $past(s2_r.tdi)) else $error("sample");
    a_reset_standby: assert property (!s2_r.device_reset_n |=> o_standby && o_func_reset) else $error("standby");
    a_init_runs: assert property (s_rel ##0 dv_r == TAR_RST |=> o_init_busy && o_load_defaults)
        else $error("init");
    a_init_ends: assert property (o_init_busy && cnt_r == 16'h0000 && s2_r.device_reset_n
        |=> !o_init_busy && !o_load_defaults && !o_func_reset) else $error("init not ended");
    a_run_released: assert property (dv_r == TAR_RUN |-> !o_func_reset && !o_standby && !o_init_busy)
        else $error("run still held");
endmodule : tar_top
`default_nettype wire

//--- verification/tar_jtag_host.sv
// Boundary-scan controller model that drives the test pins.
// Assumes the bench core clock; pins move at its falling edge.
`timescale 1ns/1ns
`default_nettype none
module tar_jtag_host (
    input  wire logic i_core_clk,
    input  wire logic i_tdo,
    input  wire logic i_tdo_oe,
    output logic      o_tck,
    output logic      o_tms,
    output logic      o_tdi,
    output logic      o_trst_n
);
    logic last_r = 1'b0;
    // Released line reads as the inverse of its last driven level
    wire  tdo_line = i_tdo_oe ? i_tdo : ~last_r;
    always @(posedge i_core_clk) if (i_tdo_oe) last_r <= i_tdo;
    initial begin
        o_tck    = 1'b0;
        o_tms    = 1'b1;
        o_tdi    = 1'b1;
        o_trst_n = 1'b0; // Held low from power-up
    end
    task automatic set_trst(input logic v);
        @(negedge i_core_clk);
        o_trst_n = v;
    endtask : set_trst
    // One 52 ns test clock period; clock stands still between calls
    task automatic step(input logic tms, input logic tdi, output logic tdo);
        @(negedge i_core_clk);
        o_tck = 1'b0;
        o_tms = tms; // Changed while the clock is low
        o_tdi = tdi;
        repeat (6) @(negedge i_core_clk);
        tdo   = tdo_line;
        o_tck = 1'b1;
        repeat (6) @(negedge i_core_clk);
    endtask : step
    task automatic nav(input logic [7:0] seq, input int n);
        logic b;
        for (int i = 0; i < n; i++) step(seq[i], 1'b1, b);
    endtask : nav
    task automatic shift(input int n, input logic [31:0] din, output logic [31:0] dout);
        logic b;
        dout = '0;
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], b);
            dout[i] = b;
        end
    endtask : shift
endmodule : tar_jtag_host
`default_nettype wire

//--- verification/tb_test_access_and_device_reset.sv
// Self-checking bench for the test port and device reset block.
// Assumes tar_top and the controller model; short init count.
`timescale 1ns/1ns
`default_nettype none
module tb_test_access_and_device_reset;
    localparam logic [31:0] IDC  = 32'h0c0d_e0f1; // Arbitrary value
    localparam int          INIT = 4;
    localparam logic [31:0] DIN  = 32'h5a5a_c3c3;
    typedef struct packed {logic [3:0] ir; logic [31:0] exp;} tar_row_t;
    // Bypass delays by one bit and captures a zero first
    localparam tar_row_t ROWS [3] = '{'{4'h1, IDC}, '{4'hf, {DIN[30:0], 1'b0}}, '{4'h2, {DIN[30:0], 1'b0}}};
    logic clk = 1'b0, rst = 1'b1, dev_n = 1'b0, en = 1'b1;
    logic tck, tms, tdi, trst_n, tdo, oe, func_rst, stby, busy, load;
    logic [31:0] got;
    int bad_count = 0, samples_checked = 0, nb, nl;
    always #2 clk = ~clk;
    tar_top #(.IDCODE(IDC), .INIT_COUNT(INIT)) u_tar_top (
        .i_core_clk(clk), .i_reset(rst), .i_clk_en(en), .i_tck(tck), .i_tms(tms), .i_tdi(tdi),
        .i_trst_n(trst_n), .i_device_reset_n(dev_n), .o_tdo(tdo), .o_tdo_oe(oe), .o_func_reset(func_rst),
        .o_standby(stby), .o_init_busy(busy), .o_load_defaults(load));
    tar_jtag_host u_tar_jtag_host (.i_core_clk(clk), .i_tdo(tdo), .i_tdo_oe(oe), .o_tck(tck), .o_tms(tms),
        .o_tdi(tdi), .o_trst_n(trst_n));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        samples_checked++;
        if (seen !== exp) begin
            $display("wrong value %s expected %h seen %h", what, exp, seen);
            bad_count++;
        end
    endtask : check
    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : results
    // Device reset pulse; with freeze the low level must not act until the enable returns
    task automatic dev_reset_test(input logic freeze);
        en = !freeze;
        dev_n = 1'b0;
        repeat (8) @(negedge clk);
        check(stby, !freeze, "standby while frozen");
        en = 1'b1;
        repeat (4) @(negedge clk);
        check(stby, 1'b1, "standby");
        check(func_rst, 1'b1, "func_reset");
        dev_n = 1'b1;
        nb = 0;
        nl = 0;
        // Busy must fall inside the bound or the count is wrong
        for (int i = 0; i < 40; i++) begin
            @(negedge clk);
            nb += busy;
            nl += load;
        end
        check(nb, INIT + 1, "init_busy cycles");
        check(nl, INIT + 1, "load_defaults cycles");
        check(func_rst, 1'b0, "func_reset after init");
        check(stby, 1'b0, "standby after init");
        $display("test device reset done");
    endtask : dev_reset_test
    initial begin
        repeat (16) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        check(oe, 1'b0, "tdo_oe");
        check(stby, 1'b1, "standby after reset");
        u_tar_jtag_host.set_trst(1'b1);
        u_tar_jtag_host.nav(8'h1f, 6);
        foreach (ROWS[r]) begin
            u_tar_jtag_host.nav(8'h03, 4);
            u_tar_jtag_host.shift(4, {28'h0, ROWS[r].ir}, got);
            check(got[3:0], tar_pkg::IR_CAPTURE, "ir capture");
            u_tar_jtag_host.nav(8'h01, 2);
            u_tar_jtag_host.nav(8'h01, 3);
            u_tar_jtag_host.shift(32, DIN, got);
            check(got, ROWS[r].exp, "dr scan");
            u_tar_jtag_host.nav(8'h01, 2);
            check(oe, 1'b0, "tdo_oe idle");
            $display("test row %0d done", r);
        end
        // Test reset in mid-shift must reselect the identification register
        u_tar_jtag_host.nav(8'h01, 3);
        u_tar_jtag_host.nav(8'h00, 3);
        check(oe, 1'b1, "tdo_oe shifting");
        u_tar_jtag_host.set_trst(1'b0);
        repeat (8) @(negedge clk);
        check(oe, 1'b0, "tdo_oe after test reset");
        u_tar_jtag_host.set_trst(1'b1);
        u_tar_jtag_host.nav(8'h02, 4);
        u_tar_jtag_host.shift(32, DIN, got);
        check(got, IDC, "idcode after test reset");
        $display("test test reset done");
        // First release, then a mid-run device reset seen through a clock-enable freeze
        dev_reset_test(1'b0);
        dev_reset_test(1'b1);
        results();
    end
endmodule : tb_test_access_and_device_reset
`default_nettype wire
